/* File: dv/tb_bit_branch_loop_cpu_control_exec.sv */
// Self-checking bench for the exec unit, driven over APB
`timescale 1ns/1ps
`default_nettype none
`include "exec_unit_regs.svh"
module tb_bit_branch_loop_cpu_control_exec;
  logic        mclk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        int_enable;
  logic [1:0]  bank_sel;
  logic        halt_mode;
  logic        stop_mode;
  logic        busy;
  logic        last_err;
  logic        rom_en;
  int          err_count;
  int          checks_done;

  exec_unit exec_unit_i (
    .MCLK       (mclk),
    .RESET_N    (reset_n),
    .PSEL       (psel),
    .PENABLE    (penable),
    .PWRITE     (pwrite),
    .PADDR      (paddr),
    .PWDATA     (pwdata),
    .PRDATA     (prdata),
    .PREADY     (pready),
    .PSLVERR    (pslverr),
    .INT_ENABLE (int_enable),
    .BANK_SEL   (bank_sel),
    .HALT_MODE  (halt_mode),
    .STOP_MODE  (stop_mode),
    .BUSY       (busy)
  );

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("mismatches %0d, comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  // Loads one instruction, starts it and judges length, time and effect
  task automatic run(input logic [3:0] op, input logic [2:0] fm,
                     input logic [2:0] bn, input logic ram,
                     input logic [7:0] od, input logic [7:0] of,
                     input logic [2:0] ln, input logic [3:0] cyc);
    logic [31:0] q;
    logic [31:0] ins;
    logic [15:0] pc;
    logic [15:0] pc_exp;
    logic        tk;
    logic [7:0]  r;
    int          n;
    pc = 16'hFFF0;
    ins = 32'h0;
    ins[3:0] = op;
    ins[6:4] = fm;
    ins[10:8] = bn;
    ins[12] = ram;
    ins[13] = rom_en;
    ins[17:16] = bn[1:0];
    tk = (op == 4'h1) ? !od[bn] : (op == 4'h3) ? (od != 8'h01) : od[bn];
    r = od;
    if (op == 4'h3) r = od - 8'h01;
    if (op == 4'h2 && tk) r = od & ~(8'h01 << bn);
    pc_exp = pc + ln + (tk ? {{8{of[7]}}, of} : 16'h0);
    apb(1'b1, `OFS_INSTR, ins, q);
    apb(1'b1, `OFS_OPND, {16'h0, of, od}, q);
    apb(1'b1, `OFS_PC, {16'h0, pc}, q);
    psel <= 1'b1;
    pwrite <= 1'b1;
    paddr <= `OFS_CTRL;
    pwdata <= 32'h1;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
    n = 0;
    while (busy === 1'b1 && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    @(posedge mclk);
    apb(1'b0, `OFS_STAT, 32'h0, q);
    if (cyc == 4'h0) begin
      check(q & 32'hE, {28'h0, !rom_en, 3'h6});
      apb(1'b0, `OFS_PC, 32'h0, q);
      check(q & 32'hFFFF, {16'h0, pc});
    end else begin
      check(32'(n), {28'h0, cyc});
      if (op < 4'h4) check(q & 32'h1F, {27'h0, tk, !rom_en, 3'h2});
      else check(q & 32'hF, {28'h0, !rom_en, 3'h2});
      apb(1'b0, `OFS_RES, 32'h0, q);
      check(q & 32'hF07, {20'h0, cyc, 5'h0, ln});
      if (op < 4'h4) begin
        apb(1'b0, `OFS_PC, 32'h0, q);
        check(q & 32'hFFFF, {16'h0, pc_exp});
        apb(1'b0, `OFS_OPND, 32'h0, q);
        check(q & 32'hFF, {24'h0, r});
      end
    end
    apb(1'b1, `OFS_CTRL, 32'h4, q);
  endtask : run

  task automatic t_bit_set();
    run(4'h0, 3'h0, 3'h3, 1'b1, 8'h08, 8'h10, 3'h3, 4'h8);
    run(4'h0, 3'h0, 3'h3, 1'b0, 8'hF7, 8'h10, 3'h3, 4'h9);
    run(4'h0, 3'h1, 3'h7, 1'b0, 8'h80, 8'hF0, 3'h4, 4'hB);
    run(4'h0, 3'h1, 3'h7, 1'b1, 8'h80, 8'hF0, 3'h4, 4'h0);
    run(4'h0, 3'h2, 3'h0, 1'b1, 8'h01, 8'h7F, 3'h3, 4'h8);
    run(4'h0, 3'h2, 3'h0, 1'b0, 8'h01, 8'h7F, 3'h3, 4'h0);
    run(4'h0, 3'h3, 3'h6, 1'b0, 8'h40, 8'h80, 3'h3, 4'h9);
    run(4'h0, 3'h4, 3'h1, 1'b1, 8'hFD, 8'h05, 3'h3, 4'hA);
    run(4'h0, 3'h4, 3'h1, 1'b0, 8'h02, 8'h05, 3'h3, 4'hB);
    rom_en = 1'b0;
    run(4'h0, 3'h2, 3'h2, 1'b1, 8'h04, 8'h02, 3'h3, 4'h8);
    rom_en = 1'b1;
  endtask : t_bit_set

  task automatic t_bit_clear();
    run(4'h1, 3'h0, 3'h5, 1'b1, 8'h00, 8'h22, 3'h4, 4'hA);
    run(4'h1, 3'h0, 3'h5, 1'b0, 8'h20, 8'h22, 3'h4, 4'hB);
    run(4'h1, 3'h1, 3'h2, 1'b0, 8'hFB, 8'hFE, 3'h4, 4'hB);
    run(4'h1, 3'h2, 3'h4, 1'b1, 8'h10, 8'h30, 3'h3, 4'h8);
    run(4'h1, 3'h3, 3'h1, 1'b0, 8'h00, 8'h81, 3'h4, 4'hB);
    run(4'h1, 3'h4, 3'h7, 1'b1, 8'h7F, 8'h04, 3'h3, 4'hA);
    run(4'h1, 3'h4, 3'h7, 1'b0, 8'h80, 8'h04, 3'h3, 4'hB);
  endtask : t_bit_clear

  task automatic t_set_clear();
    run(4'h2, 3'h0, 3'h0, 1'b1, 8'hFF, 8'h10, 3'h4, 4'hA);
    run(4'h2, 3'h0, 3'h0, 1'b0, 8'hFE, 8'h10, 3'h4, 4'hC);
    run(4'h2, 3'h1, 3'h6, 1'b0, 8'h41, 8'hE0, 3'h4, 4'hC);
    run(4'h2, 3'h2, 3'h7, 1'b1, 8'h80, 8'h01, 3'h3, 4'h8);
    run(4'h2, 3'h3, 3'h3, 1'b0, 8'h08, 8'h02, 3'h4, 4'hC);
    run(4'h2, 3'h4, 3'h5, 1'b1, 8'h20, 8'hFC, 3'h3, 4'hA);
    run(4'h2, 3'h4, 3'h5, 1'b0, 8'hDF, 8'hFC, 3'h3, 4'hC);
  endtask : t_set_clear

  task automatic t_decrement();
    run(4'h3, 3'h5, 3'h0, 1'b1, 8'h01, 8'hFE, 3'h2, 4'h6);
    run(4'h3, 3'h6, 3'h0, 1'b1, 8'h00, 8'hFE, 3'h2, 4'h6);
    run(4'h3, 3'h5, 3'h0, 1'b0, 8'h05, 8'hFE, 3'h2, 4'h0);
    run(4'h3, 3'h0, 3'h0, 1'b1, 8'h02, 8'hF8, 3'h3, 4'h8);
    run(4'h3, 3'h0, 3'h0, 1'b0, 8'h01, 8'hF8, 3'h3, 4'hA);
  endtask : t_decrement

  task automatic t_control();
    logic [31:0] q;
    run(4'h4, 3'h0, 3'h2, 1'b1, 8'h00, 8'h00, 3'h2, 4'h4);
    check({30'h0, bank_sel}, 32'h2);
    run(4'h5, 3'h0, 3'h0, 1'b0, 8'h00, 8'h00, 3'h1, 4'h2);
    run(4'h6, 3'h0, 3'h0, 1'b0, 8'h00, 8'h00, 3'h2, 4'h6);
    check({31'h0, int_enable}, 32'h1);
    run(4'h7, 3'h0, 3'h0, 1'b1, 8'h00, 8'h00, 3'h2, 4'h6);
    check({31'h0, int_enable}, 32'h0);
    run(4'h8, 3'h0, 3'h0, 1'b1, 8'h00, 8'h00, 3'h2, 4'h6);
    check({30'h0, stop_mode, halt_mode}, 32'h1);
    apb(1'b1, `OFS_CTRL, 32'h2, q);
    run(4'h9, 3'h0, 3'h0, 1'b0, 8'h00, 8'h00, 3'h2, 4'h6);
    check({30'h0, stop_mode, halt_mode}, 32'h2);
    apb(1'b1, `OFS_CTRL, 32'h2, q);
    check({30'h0, stop_mode, halt_mode}, 32'h0);
    run(4'hA, 3'h0, 3'h0, 1'b1, 8'h00, 8'h00, 3'h2, 4'h0);
  endtask : t_control

  // Reads of an unmapped place and of the control register on the register bus
  task automatic t_bus();
    logic [31:0] q;
    apb(1'b0, 12'h018, 32'h0, q);
    check({q[31:1], last_err}, 32'h1);
    apb(1'b0, `OFS_CTRL, 32'h0, q);
    check({q[31:1], last_err}, 32'h0);
  endtask : t_bus

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    err_count = 0;
    checks_done = 0;
    rom_en = 1'b1;
    last_err = 1'b0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_bus();
    t_bit_set();
    t_bit_clear();
    t_set_clear();
    t_decrement();
    t_control();
    tally_and_finish();
  end
endmodule : tb_bit_branch_loop_cpu_control_exec
`default_nettype wire

/* File: logic/bit_exec.sv */
// Bit test, clear, decrement and target address arithmetic
`timescale 1ns/1ps
`default_nettype none
module bit_exec (
  input  wire logic [3:0]  op,
  input  wire logic [2:0]  bitno,
  input  wire logic [7:0]  opnd,
  input  wire logic [7:0]  offs,
  input  wire logic [15:0] pc,
  input  wire logic [2:0]  len,
  output logic             taken,
  output logic      [7:0]  result,
  output logic      [15:0] next_pc
);
  always_comb begin
    result = opnd;
    taken = 1'b0;
    case (op)
      exec_pkg::OP_BSET: taken = opnd[bitno]; // RULE4
      exec_pkg::OP_BCLR: taken = !opnd[bitno]; // RULE9
      exec_pkg::OP_BSCLR: begin
        taken = opnd[bitno];
        // Status word flags change simply because the byte changes
        if (taken) result[bitno] = 1'b0; // RULE14 RULE17
      end
      exec_pkg::OP_DEC: begin
        result = opnd - 8'h01; // RULE19 RULE20
        taken = result != 8'h00;
      end
      default: taken = 1'b0;
    endcase
    next_pc = pc + {13'h0000, len}; // RULE26
    if (taken) next_pc = next_pc + {{8{offs[7]}}, offs};
  end
endmodule : bit_exec
`default_nettype wire

/* File: logic/exec_pkg.sv */
// Operation, operand form and state types of the exec unit
`default_nettype none
package exec_pkg;
  typedef enum logic [3:0] {
    OP_BSET  = 4'h0,
    OP_BCLR  = 4'h1,
    OP_BSCLR = 4'h2,
    OP_DEC   = 4'h3,
    OP_SEL   = 4'h4,
    OP_IDLE  = 4'h5,
    OP_INTON = 4'h6,
    OP_INTOFF = 4'h7,
    OP_LIGHT = 4'h8,
    OP_DEEP  = 4'h9
  } op_e;
  typedef enum logic [2:0] {
    F_SADDR = 3'h0,
    F_SFR   = 3'h1,
    F_ACC   = 3'h2,
    F_STATW = 3'h3,
    F_PTR   = 3'h4,
    F_REGB  = 3'h5,
    F_REGC  = 3'h6
  } form_e;
  typedef enum logic [0:0] {
    S_IDLE = 1'b0,
    S_EXEC = 1'b1
  } state_e;
endpackage : exec_pkg
`default_nettype wire

/* File: logic/exec_timing.sv */
// Length and cycle lookup per operation and operand form
`timescale 1ns/1ps
`default_nettype none
`include "exec_unit_regs.svh"
module exec_timing (
  input  wire logic [3:0] op,
  input  wire logic [2:0] form,
  input  wire logic       ram,
  output logic      [2:0] len,
  output logic      [3:0] cyc,
  output logic            legal
);
  logic [3:0] c_ram;
  logic [3:0] c_ext;
  always_comb begin
    len = `LEN_CTL;
    c_ram = `CYC_DASH;
    c_ext = `CYC_DASH;
    case ({op, form})
      {exec_pkg::OP_BSET, exec_pkg::F_SADDR}:
        {len, c_ram, c_ext} = {`LEN_MID, `CYC_FAST, `CYC_BIT9}; // RULE4
      {exec_pkg::OP_BSET, exec_pkg::F_SFR}:
        {len, c_ext} = {`LEN_LONG, `CYC_SLOWX}; // RULE5
      {exec_pkg::OP_BSET, exec_pkg::F_ACC}:
        {len, c_ram} = {`LEN_MID, `CYC_FAST}; // RULE6
      {exec_pkg::OP_BSET, exec_pkg::F_STATW}:
        {len, c_ext} = {`LEN_MID, `CYC_BIT9}; // RULE7
      {exec_pkg::OP_BSET, exec_pkg::F_PTR}:
        {len, c_ram, c_ext} = {`LEN_MID, `CYC_SLOW, `CYC_SLOWX}; // RULE8
      {exec_pkg::OP_BCLR, exec_pkg::F_SADDR}:
        {len, c_ram, c_ext} = {`LEN_LONG, `CYC_SLOW, `CYC_SLOWX}; // RULE9
      {exec_pkg::OP_BCLR, exec_pkg::F_SFR}:
        {len, c_ext} = {`LEN_LONG, `CYC_SLOWX}; // RULE10
      {exec_pkg::OP_BCLR, exec_pkg::F_ACC}:
        {len, c_ram} = {`LEN_MID, `CYC_FAST}; // RULE11
      {exec_pkg::OP_BCLR, exec_pkg::F_STATW}:
        {len, c_ext} = {`LEN_LONG, `CYC_SLOWX}; // RULE12
      {exec_pkg::OP_BCLR, exec_pkg::F_PTR}:
        {len, c_ram, c_ext} = {`LEN_MID, `CYC_SLOW, `CYC_SLOWX}; // RULE13
      {exec_pkg::OP_BSCLR, exec_pkg::F_SADDR}:
        {len, c_ram, c_ext} = {`LEN_LONG, `CYC_SLOW, `CYC_CLRX}; // RULE14
      {exec_pkg::OP_BSCLR, exec_pkg::F_SFR}:
        {len, c_ext} = {`LEN_LONG, `CYC_CLRX}; // RULE15
      {exec_pkg::OP_BSCLR, exec_pkg::F_ACC}:
        {len, c_ram} = {`LEN_MID, `CYC_FAST}; // RULE16
      {exec_pkg::OP_BSCLR, exec_pkg::F_STATW}:
        {len, c_ext} = {`LEN_LONG, `CYC_CLRX}; // RULE17
      {exec_pkg::OP_BSCLR, exec_pkg::F_PTR}:
        {len, c_ram, c_ext} = {`LEN_MID, `CYC_SLOW, `CYC_CLRX}; // RULE18
      {exec_pkg::OP_DEC, exec_pkg::F_REGB},
      {exec_pkg::OP_DEC, exec_pkg::F_REGC}: c_ram = `CYC_CTL; // RULE19
      {exec_pkg::OP_DEC, exec_pkg::F_SADDR}:
        {len, c_ram, c_ext} = {`LEN_MID, `CYC_FAST, `CYC_SLOW}; // RULE20
      default: begin
        case (op)
          exec_pkg::OP_INTON: c_ext = `CYC_CTL; // RULE21
          exec_pkg::OP_INTOFF: c_ext = `CYC_CTL; // RULE22
          exec_pkg::OP_SEL: c_ram = `CYC_SEL; // RULE23
          exec_pkg::OP_IDLE: {len, c_ram} = {`LEN_NOP, `CYC_NOP}; // RULE23
          exec_pkg::OP_LIGHT,
          exec_pkg::OP_DEEP: c_ram = `CYC_CTL; // RULE24
          default: c_ram = `CYC_DASH;
        endcase
      end
    endcase
    // Control ops with one column run from either area
    if (op >= exec_pkg::OP_SEL && op <= exec_pkg::OP_DEEP) begin
      c_ext = (c_ext == `CYC_DASH) ? c_ram : c_ext;
      c_ram = (c_ram == `CYC_DASH) ? c_ext : c_ram;
    end
    cyc = ram ? c_ram : c_ext; // RULE2 RULE25
    legal = cyc != `CYC_DASH; // RULE25
  end
endmodule : exec_timing
`default_nettype wire

/* File: logic/exec_unit.sv */
// Exec unit for bit branches, loop decrement and CPU control ops
`timescale 1ns/1ps
`default_nettype none
`include "exec_unit_regs.svh"
module exec_unit (
  input  wire logic        MCLK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             INT_ENABLE,
  output logic      [1:0]  BANK_SEL,
  output logic             HALT_MODE,
  output logic             STOP_MODE,
  output logic             BUSY
);
  logic                  rst_meta;
  logic                  rst_n;
  exec_pkg::state_e      state;
  exec_pkg::state_e      next_state;
  logic [3:0]            count;
  logic [3:0]            next_count;
  logic [3:0]            op;
  logic [3:0]            next_op;
  logic [2:0]            form;
  logic [2:0]            next_form;
  logic [2:0]            bitno;
  logic [2:0]            next_bitno;
  logic                  ram;
  logic                  next_ram;
  logic                  rom;
  logic                  next_rom;
  logic [1:0]            bank_n;
  logic [1:0]            next_bank_n;
  logic [15:0]           pc;
  logic [15:0]           next_pc;
  logic [7:0]            opnd;
  logic [7:0]            next_opnd;
  logic [7:0]            offs;
  logic [7:0]            next_offs;
  logic                  done;
  logic                  next_done;
  logic                  illegal;
  logic                  next_illegal;
  logic                  uncovered;
  logic                  next_uncovered;
  logic                  taken;
  logic                  next_taken;
  logic                  ie;
  logic                  next_ie;
  logic [1:0]            bank;
  logic [1:0]            next_bank;
  logic                  halt;
  logic                  next_halt;
  logic                  stop;
  logic                  next_stop;
  logic [2:0]            len_lat;
  logic [2:0]            next_len_lat;
  logic [3:0]            cyc_lat;
  logic [3:0]            next_cyc_lat;
  logic [31:0]           next_prdata;
  logic [2:0]            t_len;
  logic [3:0]            t_cyc;
  logic                  t_legal;
  logic                  x_taken;
  logic [7:0]            x_result;
  logic [15:0]           x_pc;
  logic                  wr_acc;
  logic                  sel_ctrl;
  logic                  sel_instr;
  logic                  sel_pc;
  logic                  sel_opnd;
  logic                  sel_stat;
  logic                  sel_res;
  logic                  mapped;
  logic                  go;
  logic                  commit;

  // Reset enters asynchronously but is released on the clock
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  exec_timing exec_timing_i (
    .op    (op),
    .form  (form),
    .ram   (ram),
    .len   (t_len),
    .cyc   (t_cyc),
    .legal (t_legal)
  );

  bit_exec bit_exec_i (
    .op      (op),
    .bitno   (bitno),
    .opnd    (opnd),
    .offs    (offs),
    .pc      (pc),
    .len     (len_lat),
    .taken   (x_taken),
    .result  (x_result),
    .next_pc (x_pc)
  );

  assign sel_ctrl = PADDR == `OFS_CTRL;
  assign sel_instr = PADDR == `OFS_INSTR;
  assign sel_pc = PADDR == `OFS_PC;
  assign sel_opnd = PADDR == `OFS_OPND;
  assign sel_stat = PADDR == `OFS_STAT;
  assign sel_res = PADDR == `OFS_RES;
  assign mapped = |{sel_ctrl, sel_instr, sel_pc, sel_opnd, sel_stat, sel_res};
  // Zero wait states keep the master's access phase to one cycle
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign wr_acc = PSEL && PENABLE && PWRITE && mapped;
  assign go = wr_acc && sel_ctrl && PWDATA[`F_GO];
  assign commit = state == exec_pkg::S_EXEC && count == 4'h1;

  always_comb begin
    next_state = state;
    next_count = count;
    next_op = op;
    next_form = form;
    next_bitno = bitno;
    next_ram = ram;
    next_rom = rom;
    next_bank_n = bank_n;
    next_pc = pc;
    next_opnd = opnd;
    next_offs = offs;
    next_done = done;
    next_illegal = illegal;
    next_uncovered = uncovered;
    next_taken = taken;
    next_ie = ie;
    next_bank = bank;
    next_halt = halt;
    next_stop = stop;
    next_len_lat = len_lat;
    next_cyc_lat = cyc_lat;
    if (wr_acc && sel_ctrl && PWDATA[`F_WAKE]) begin
      next_halt = 1'b0;
      next_stop = 1'b0;
    end
    if (wr_acc && sel_ctrl && PWDATA[`F_ACK]) next_done = 1'b0;
    unique case (state)
      exec_pkg::S_IDLE: begin
        // Operands are frozen while busy so the result cannot tear
        if (wr_acc && sel_instr) begin
          next_op = PWDATA[`F_OP];
          next_form = PWDATA[`F_FORM];
          next_bitno = PWDATA[`F_BIT];
          next_ram = PWDATA[`F_RAM];
          next_rom = PWDATA[`F_ROM];
          next_bank_n = PWDATA[`F_BANK];
        end
        if (wr_acc && sel_pc) next_pc = PWDATA[`F_PC];
        if (wr_acc && sel_opnd) begin
          next_opnd = PWDATA[`F_DATA];
          next_offs = PWDATA[`F_OFFS];
        end
        if (go) begin
          next_len_lat = t_len;
          next_cyc_lat = t_cyc;
          next_taken = 1'b0;
          next_uncovered = !rom; // RULE3
          next_done = !t_legal;
          next_illegal = !t_legal; // RULE25
          if (t_legal) begin
            next_state = exec_pkg::S_EXEC;
            next_count = t_cyc; // RULE1
          end
        end
      end
      exec_pkg::S_EXEC: begin
        next_count = count - 4'h1; // RULE1
        if (count == 4'h1) begin
          next_state = exec_pkg::S_IDLE;
          next_pc = x_pc; // RULE26
          next_opnd = x_result; // RULE14 RULE19
          next_taken = x_taken;
          // Set of done wins over an acknowledge in the same cycle
          next_done = 1'b1;
          case (op)
            exec_pkg::OP_INTON: next_ie = 1'b1; // RULE21
            exec_pkg::OP_INTOFF: next_ie = 1'b0; // RULE22
            exec_pkg::OP_SEL: next_bank = bank_n; // RULE23
            exec_pkg::OP_LIGHT: next_halt = 1'b1; // RULE24
            exec_pkg::OP_DEEP: next_stop = 1'b1; // RULE24
            default: next_ie = ie;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= exec_pkg::S_IDLE;
      count <= 4'h0;
      op <= 4'h0;
      form <= 3'h0;
      bitno <= 3'h0;
      ram <= 1'b0;
      rom <= 1'b0;
      bank_n <= 2'h0;
      pc <= `RST_PC;
      opnd <= 8'h00;
      offs <= 8'h00;
      done <= 1'b0;
      illegal <= 1'b0;
      uncovered <= 1'b0;
      taken <= 1'b0;
      ie <= 1'b0;
      bank <= `RST_BANK;
      halt <= 1'b0;
      stop <= 1'b0;
      len_lat <= 3'h0;
      cyc_lat <= 4'h0;
    end else begin
      state <= next_state;
      count <= next_count;
      op <= next_op;
      form <= next_form;
      bitno <= next_bitno;
      ram <= next_ram;
      rom <= next_rom;
      bank_n <= next_bank_n;
      pc <= next_pc;
      opnd <= next_opnd;
      offs <= next_offs;
      done <= next_done;
      illegal <= next_illegal;
      uncovered <= next_uncovered;
      taken <= next_taken;
      ie <= next_ie;
      bank <= next_bank;
      halt <= next_halt;
      stop <= next_stop;
      len_lat <= next_len_lat;
      cyc_lat <= next_cyc_lat;
    end
  end

  // Read data is prepared in the setup cycle so PRDATA is a flop
  always_comb begin
    next_prdata = PRDATA;
    if (PSEL && !PENABLE && !PWRITE) begin
      next_prdata = 32'h0000_0000;
      if (sel_instr) begin
        next_prdata[`F_OP] = op;
        next_prdata[`F_FORM] = form;
        next_prdata[`F_BIT] = bitno;
        next_prdata[`F_RAM] = ram;
        next_prdata[`F_ROM] = rom;
        next_prdata[`F_BANK] = bank_n;
      end
      if (sel_pc) next_prdata[`F_PC] = pc;
      if (sel_opnd) next_prdata[15:0] = {offs, opnd};
      if (sel_stat) begin
        next_prdata[9:0] = {stop, halt, bank, ie, taken, uncovered,
                            illegal, done, state == exec_pkg::S_EXEC};
      end
      if (sel_res) next_prdata[11:0] = {cyc_lat, 5'h00, len_lat};
    end
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) PRDATA <= 32'h0000_0000;
    else PRDATA <= next_prdata;
  end

  assign INT_ENABLE = ie;
  assign BANK_SEL = bank;
  assign HALT_MODE = halt;
  assign STOP_MODE = stop;
  assign BUSY = state == exec_pkg::S_EXEC;

  // Cycles spent in the current execution, for checking only
  logic [3:0] elapsed;
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) elapsed <= 4'h0;
    else if (state == exec_pkg::S_IDLE) elapsed <= 4'h1;
    else elapsed <= elapsed + 4'h1;
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!rst_n);

  cycle_count_a: assert property ( // RULE1
    commit |-> elapsed == cyc_lat)
    else $error("execution length differs from cycle count");
  col_two_a: assert property ( // RULE2
    go && !ram && op == exec_pkg::OP_BSET && form == exec_pkg::F_SADDR
    |=> BUSY && cyc_lat == `CYC_BIT9)
    else $error("second column not used outside RAM");
  col_one_a: assert property ( // RULE25
    go && ram && op == exec_pkg::OP_BSET && form == exec_pkg::F_SFR
    |=> !BUSY && illegal && done)
    else $error("dash entry not refused");
  rom_flag_a: assert property ( // RULE3
    go |=> uncovered == !$past(rom))
    else $error("fetch source flag wrong");
  set_branch_a: assert property ( // RULE4
    commit && op == exec_pkg::OP_BSET && opnd[bitno]
    |=> pc == $past(pc) + {13'h0000, len_lat} + {{8{offs[7]}}, offs})
    else $error("taken branch target wrong");
  clr_taken_a: assert property ( // RULE9
    commit && op == exec_pkg::OP_BCLR |=> taken == !$past(opnd[bitno]))
    else $error("clear branch condition wrong");
  clr_bit_a: assert property ( // RULE14
    commit && op == exec_pkg::OP_BSCLR && opnd[bitno]
    |=> !opnd[bitno] && taken && done)
    else $error("tested bit not cleared");
  dec_loop_a: assert property ( // RULE19
    commit && op == exec_pkg::OP_DEC
    |=> opnd == $past(opnd) - 8'h01 && taken == (opnd != 8'h00))
    else $error("decrement loop wrong");
  int_on_a: assert property ( // RULE21
    go && op == exec_pkg::OP_INTON && !ram ##1 BUSY[*6] |=> INT_ENABLE)
    else $error("interrupt enable not set after six cycles");
  int_off_a: assert property ( // RULE22
    commit && op == exec_pkg::OP_INTOFF |=> !INT_ENABLE && !BUSY)
    else $error("interrupt enable not cleared");
  bank_load_a: assert property ( // RULE23
    commit && op == exec_pkg::OP_SEL |=> BANK_SEL == $past(bank_n))
    else $error("bank not loaded");
  sleep_a: assert property ( // RULE24
    commit && op == exec_pkg::OP_DEEP |=> STOP_MODE)
    else $error("deep sleep not entered");
  fall_thru_a: assert property ( // RULE26
    commit && !x_taken && op != exec_pkg::OP_DEC
    |=> pc == $past(pc) + {13'h0000, len_lat} && $stable(opnd))
    else $error("untaken branch did not fall through");

  taken_clr_c: cover property (commit && op == exec_pkg::OP_BSCLR && x_taken);
  loop_end_c: cover property (commit && op == exec_pkg::OP_DEC && !x_taken);
  refused_c: cover property (go && !t_legal);
  light_c: cover property (commit && op == exec_pkg::OP_LIGHT);
endmodule : exec_unit
`default_nettype wire

/* File: logic/exec_unit_regs.svh */
// Register offsets, field positions and cycle counts of the exec unit
// Contract
// RULE1 - One counted cycle per CPU clock
// RULE2 - Non-RAM data access uses second cycle column
// RULE3 - Counts hold only for internal ROM fetch
// RULE4 - Bit-set branch, short direct: 3 bytes, 8/9
// RULE5 - Bit-set branch, special reg: 4 bytes, 11
// RULE6 - Bit-set branch, accumulator: 3 bytes, 8
// RULE7 - Bit-set branch, status word: 3 bytes, 9
// RULE8 - Bit-set branch, pointer pair: 3 bytes, 10/11
// RULE9 - Bit-clear branch, short direct: 4 bytes, 10/11
// RULE10 - Bit-clear branch, special reg: 4 bytes, 11
// RULE11 - Bit-clear branch, accumulator: 3 bytes, 8
// RULE12 - Bit-clear branch, status word: 4 bytes, 11
// RULE13 - Bit-clear branch, pointer pair: 3 bytes, 10/11
// RULE14 - Set-and-clear, short direct: 4 bytes, 10/12
// RULE15 - Set-and-clear, special reg: 4 bytes, 12
// RULE16 - Set-and-clear, accumulator: 3 bytes, 8
// RULE17 - Set-and-clear, status word: 4 bytes, 12
// RULE18 - Set-and-clear, pointer pair: 3 bytes, 10/12
// RULE19 - Decrement B or C, branch nonzero: 2, 6
// RULE20 - Decrement short direct byte: 3 bytes, 8/10
// RULE21 - Interrupt enable: 2 bytes, 6, flag set
// RULE22 - Interrupt disable: 2 bytes, 6, flag cleared
// RULE23 - Bank select 2/4; no-op 1/2
// RULE24 - Light and deep sleep: 2 bytes, 6
// RULE25 - RAM access uses first column; dash illegal
// RULE26 - Untaken branch falls through, bit untouched
`ifndef EXEC_UNIT_REGS_SVH
`define EXEC_UNIT_REGS_SVH
`define OFS_CTRL 12'h000
`define OFS_INSTR 12'h004
`define OFS_PC 12'h008
`define OFS_OPND 12'h00C
`define OFS_STAT 12'h010
`define OFS_RES 12'h014
`define F_GO 0
`define F_WAKE 1
`define F_ACK 2
`define F_OP 3:0
`define F_FORM 6:4
`define F_BIT 10:8
`define F_RAM 12
`define F_ROM 13
`define F_BANK 17:16
`define F_DATA 7:0
`define F_OFFS 15:8
`define F_PC 15:0
`define RST_PC 16'h0000
`define RST_BANK 2'h0
`define LEN_NOP 3'h1
`define LEN_CTL 3'h2
`define LEN_MID 3'h3
`define LEN_LONG 3'h4
`define CYC_DASH 4'h0
`define CYC_NOP 4'h2
`define CYC_SEL 4'h4
`define CYC_CTL 4'h6
`define CYC_FAST 4'h8
`define CYC_BIT9 4'h9
`define CYC_SLOW 4'hA
`define CYC_SLOWX 4'hB
`define CYC_CLRX 4'hC
`endif
